// File: rtl/lbus_arbiter.sv
// Purpose: local bus arbiter with DRAM and boot memory cycle timing
// Assumes: masters hold request until done; one bus clock domain
// Notes: beat timing counted per beat; data path not modelled
// Operation
// - Fixed priority: LAN 0, module DMA 1, SCSI 2, VME 3, processor 4.
// - DRAM base, array size and device size come from software settings.
// - Interleave when configuration needs eight devices: 4MB/4Mbit or 16MB/16Mbit.
// - Parity check enable and parity error action are software settings.
// - 25 MHz beats: reads 4,2,2,2 or interleaved 4,1,1,1; writes 3,2,2,2.
// - 32 MHz beats: reads 5,3,3,3 or interleaved 5,2,2,2; writes 4,2,2,2.
// - Boot path: 3 to 10 clocks per byte, four bytes per longword.
// - SCSI DMA moves local bus data in bursts of four longwords.
// - LAN DMA issues only single transfers, never bursts.
// - LAN single DRAM write 3 or 4 clocks, single read 5 clocks; here a 25 MHz single read takes 4 clocks.
// - Respond only to normal-access and interrupt-acknowledge transfer kinds.
// - Transfer kinds 0, 1 and 2 form the normal address range.
// - Timeout with timer enabled ends the access with transfer error ack.
`timescale 1ns/1ns
`include "lbus_defines.svh"
module lbus_arbiter #(
    parameter int NM = `N_MASTERS
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [NM-1:0] req_i,
    input wire logic [NM-1:0] burst_i,
    input wire logic write_i,
    input wire logic [1:0] access_kind_lines_i,
    input wire logic [31:0] addr_i,
    input wire logic parity_err_i,
    input wire logic [31:0] dram_base_i,
    input wire logic [1:0] array_size_i,
    input wire logic dev_16mbit_i,
    input wire logic dram_en_i,
    input wire logic bus_32mhz_i,
    input wire logic parity_en_i,
    input wire logic parity_trap_i,
    input wire logic [3:0] boot_clocks_i,
    input wire lbus_pkg::tmo_sel_t tmo_sel_i,
    output logic [NM-1:0] grant_o,
    output logic beat_ack_o,
    output logic transfer_error_ack_o,
    output logic interleaved_o,
    output logic parity_flag_o
);
    import lbus_pkg::*;

    // Priority table and tags are fixed for five masters
    if (NM != 5) begin : g_nm_check
        $error("lbus_arbiter serves exactly five masters");
    end

    localparam logic [15:0] T8 = 16'(`TMO_8US_CYC);
    localparam logic [15:0] T64 = 16'(`TMO_64US_CYC);
    localparam logic [15:0] T256 = 16'(`TMO_256US_CYC);

    // Lowest index wins
    function automatic logic [NM-1:0] pick(input logic [NM-1:0] r);
        logic [NM-1:0] g;
        g = '0;
        for (int i = NM - 1; i >= 0; i--) begin
            if (r[i]) g = '0;
            if (r[i]) g[i] = 1'b1;
        end
        return g;
    endfunction : pick

    // Clocks for beat b of a DRAM cycle
    function automatic logic [3:0] beat_len(input logic fast, input logic wr,
                                            input logic il, input logic first);
        logic [3:0] n;
        n = 4'h2;
        if (wr) n = first ? (fast ? 4'h4 : 4'h3) : 4'h2;
        else if (il) n = first ? (fast ? 4'h5 : 4'h4) : (fast ? 4'h2 : 4'h1);
        else n = first ? (fast ? 4'h5 : 4'h4) : (fast ? 4'h3 : 4'h2);
        return n;
    endfunction : beat_len

    // Array size code: 0=4MB 1=8MB 2=16MB
    logic interleave;
    logic [31:0] span;
    logic is_normal;
    logic is_iack;
    target_t tgt;
    always_comb begin
        interleave = (array_size_i == 2'h0 && !dev_16mbit_i) ||
                     (array_size_i == 2'h2 && dev_16mbit_i);
        span = 32'h0040_0000 << array_size_i;
        is_normal = access_kind_lines_i == `TT_NORMAL0 || access_kind_lines_i == `TT_NORMAL1 ||
                    access_kind_lines_i == `TT_NORMAL2;
        is_iack = access_kind_lines_i == `TT_IACK;
        if (is_normal && dram_en_i && addr_i - dram_base_i < span) tgt = TGT_DRAM;
        else if (is_normal && addr_i[31:22] == 10'h3FE) tgt = TGT_BOOT;
        else tgt = TGT_OTHER;
    end

    state_t st_q, st_d;
    logic [NM-1:0] grant_q, grant_d;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] beat_q, beat_d;
    logic [1:0] nbeats_q, nbeats_d;
    logic wr_q, wr_d;
    logic il_q, il_d;
    logic ack_q, ack_d;
    logic tea_q, tea_d;
    logic par_q, par_d;
    logic [15:0] tmo_q, tmo_d;
    logic [3:0] boot_n;
    logic [15:0] tmo_lim;

    always_comb begin
        boot_n = boot_clocks_i;
        if (boot_n < `BOOT_MIN) boot_n = `BOOT_MIN;
        if (boot_n > `BOOT_MAX) boot_n = `BOOT_MAX;
        case (tmo_sel_i)
            TMO_8US: tmo_lim = T8;
            TMO_64US: tmo_lim = T64;
            TMO_256US: tmo_lim = T256;
            default: tmo_lim = 16'hFFFF;
        endcase
    end

    always_comb begin
        st_d = st_q;
        grant_d = grant_q;
        cnt_d = cnt_q;
        beat_d = beat_q;
        nbeats_d = nbeats_q;
        wr_d = wr_q;
        il_d = il_q;
        ack_d = 1'b0;
        tea_d = 1'b0;
        par_d = par_q;
        tmo_d = tmo_q;
        case (st_q)
            ST_IDLE: begin
                grant_d = pick(req_i);
                tmo_d = '0;
                // Stale burst count must not leak into the next owner
                nbeats_d = '0;
                if (req_i != '0) begin
                    st_d = ST_OTHER;
                end
            end
            ST_OTHER: begin
                // Decode once the granted master drives its cycle
                beat_d = '0;
                wr_d = write_i;
                il_d = interleave;
                nbeats_d = ((grant_q & burst_i) != '0 && !grant_q[`M_LAN]) ?
                           2'h3 : 2'h0;
                if (!is_normal && !is_iack) begin
                    st_d = ST_DONE;
                end else if (tgt == TGT_DRAM) begin
                    // Decode cycle is the first clock of the budget
                    cnt_d = beat_len(bus_32mhz_i, write_i, interleave, 1'b1) -
                            4'h2;
                    st_d = ST_DRAM;
                end else if (tgt == TGT_BOOT) begin
                    cnt_d = boot_n - 4'h2;
                    st_d = ST_BOOT;
                end else begin
                    // Unclaimed: wait for timer
                    tmo_d = tmo_q + 16'h1;
                    if (tmo_sel_i != TMO_OFF && tmo_q + 16'h1 >= tmo_lim) begin
                        tea_d = 1'b1;
                        st_d = ST_DONE;
                    end
                end
            end
            ST_DRAM: begin
                if (cnt_q == 4'h0) begin
                    ack_d = 1'b1;
                    if (parity_en_i && parity_err_i && !wr_q) begin
                        par_d = 1'b1;
                        if (parity_trap_i) tea_d = 1'b1;
                        if (parity_trap_i) ack_d = 1'b0;
                    end
                    if (beat_q == nbeats_q || tea_d) begin
                        st_d = ST_DONE;
                    end else begin
                        beat_d = beat_q + 2'h1;
                        cnt_d = beat_len(bus_32mhz_i, wr_q, il_q, 1'b0) - 4'h1;
                    end
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_BOOT: begin
                // Four byte cycles per longword
                if (cnt_q == 4'h0) begin
                    cnt_d = boot_n - 4'h1;
                    beat_d = beat_q + 2'h1;
                    if (beat_q == 2'h3) begin
                        ack_d = 1'b1;
                        beat_d = '0;
                        if (nbeats_q == 2'h0) st_d = ST_DONE;
                        else nbeats_d = nbeats_q - 2'h1;
                    end
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_DONE: begin
                grant_d = '0;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_q <= ST_IDLE;
            grant_q <= '0;
            cnt_q <= '0;
            beat_q <= '0;
            nbeats_q <= '0;
            wr_q <= 1'b0;
            il_q <= 1'b0;
            ack_q <= 1'b0;
            tea_q <= 1'b0;
            par_q <= 1'b0;
            tmo_q <= '0;
        end else begin
            st_q <= st_d;
            grant_q <= grant_d;
            cnt_q <= cnt_d;
            beat_q <= beat_d;
            nbeats_q <= nbeats_d;
            wr_q <= wr_d;
            il_q <= il_d;
            ack_q <= ack_d;
            tea_q <= tea_d;
            par_q <= par_d;
            tmo_q <= tmo_d;
        end
    end

    assign grant_o = grant_q;
    assign beat_ack_o = ack_q;
    assign transfer_error_ack_o = tea_q;
    assign interleaved_o = il_q;
    assign parity_flag_o = par_q;

    property p_onehot;
        @(posedge ref_clk_i) disable iff (!rst_n_i) $onehot0(grant_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two grants");

    property p_lan_first;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (st_q == ST_IDLE && req_i[`M_LAN]) |=> grant_o[`M_LAN];
    endproperty
    a_lan_first: assert property (p_lan_first) else $error("LAN not granted first");

    property p_cpu_last;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (st_q == ST_IDLE && req_i[3:0] != '0) |=> !grant_o[`M_CPU];
    endproperty
    a_cpu_last: assert property (p_cpu_last) else $error("processor beat a higher master");

    property p_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (grant_o != '0 && st_q != ST_DONE) |=> grant_o == $past(grant_o);
    endproperty
    a_hold: assert property (p_hold) else $error("grant moved mid transfer");

    sequence s_wr_start;
        st_q == ST_OTHER && tgt == TGT_DRAM && write_i && !bus_32mhz_i;
    endsequence
    property p_wr25;
        @(posedge ref_clk_i) disable iff (!rst_n_i) s_wr_start |-> ##3 beat_ack_o;
    endproperty
    a_wr25: assert property (p_wr25) else $error("25 MHz write first beat not 3");

    property p_wr32;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (st_q == ST_OTHER && tgt == TGT_DRAM && write_i && bus_32mhz_i)
            |-> ##4 beat_ack_o;
    endproperty
    a_wr32: assert property (p_wr32) else $error("32 MHz write first beat not 4");

    property p_rd_single;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (st_q == ST_OTHER && tgt == TGT_DRAM && !write_i && bus_32mhz_i && grant_q[`M_LAN]
             && !(parity_en_i && parity_trap_i)) |-> !beat_ack_o [*5] ##1 beat_ack_o;
    endproperty
    a_rd_single: assert property (p_rd_single) else $error("LAN read not 5 clocks");

    property p_lan_single;
        @(posedge ref_clk_i) disable iff (!rst_n_i) grant_q[`M_LAN] |-> nbeats_q == 2'h0;
    endproperty
    a_lan_single: assert property (p_lan_single) else $error("LAN burst");

    property p_ignore;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (st_q == ST_OTHER && !is_normal && !is_iack) |=> !beat_ack_o && !transfer_error_ack_o;
    endproperty
    a_ignore: assert property (p_ignore) else $error("answered other transfer kind");

    property p_il;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (st_q == ST_OTHER && ((array_size_i == 2'h2 && dev_16mbit_i) ||
             (array_size_i == 2'h0 && !dev_16mbit_i))) |=> interleaved_o;
    endproperty
    a_il: assert property (p_il) else $error("eight-device array not interleaved");
endmodule : lbus_arbiter

// File: rtl/lbus_defines.svh
// Purpose: constants for the local bus arbiter and memory timing block
// Assumes: bus clock 10 MHz in this build, budgets expressed in bus clocks
// Notes: definitions only
`ifndef LBUS_DEFINES_SVH
`define LBUS_DEFINES_SVH
`define CLK_PERIOD_NS 100
`define N_MASTERS 5
`define M_LAN 0
`define M_SLOT 1
`define M_SCSI 2
`define M_VME 3
`define M_CPU 4
`define TT_NORMAL0 2'h0
`define TT_NORMAL1 2'h1
`define TT_NORMAL2 2'h2
`define TT_IACK 2'h3
`define BOOT_MIN 4'h3
`define BOOT_MAX 4'hA
`define TMO_8US_NS 8000
`define TMO_64US_NS 64000
`define TMO_256US_NS 256000
`define TMO_8US_CYC ((`TMO_8US_NS) / (`CLK_PERIOD_NS))
`define TMO_64US_CYC ((`TMO_64US_NS) / (`CLK_PERIOD_NS))
`define TMO_256US_CYC ((`TMO_256US_NS) / (`CLK_PERIOD_NS))
`endif

// File: rtl/lbus_pkg.sv
// Purpose: types for the local bus arbiter and memory timing block
// Assumes: nothing
// Notes: constants live in lbus_defines.svh
package lbus_pkg;
    typedef enum logic [1:0] {TGT_DRAM, TGT_BOOT, TGT_OTHER} target_t;
    typedef enum logic [1:0] {TMO_8US, TMO_64US, TMO_256US, TMO_OFF} tmo_sel_t;
    typedef enum {ST_IDLE, ST_DRAM, ST_BOOT, ST_OTHER, ST_DONE} state_t;
endpackage : lbus_pkg

// File: verif/lbus_arbiter_tb_top.sv
// Purpose: self-checking bench for the local bus arbiter
// Assumes: 100 ns clock, budgets counted from the grant cycle
// Notes: random masks, DRAM bases and addresses from a fixed seed; array sizes swept in order
`timescale 1ns/1ns
`include "lbus_defines.svh"
module lbus_arbiter_tb_top;
    import lbus_pkg::*;
    logic ref_clk_i, rst_n_i, write_i, parity_err_i, dev_16mbit_i, dram_en_i;
    logic bus_32mhz_i, parity_en_i, parity_trap_i, beat_ack_o, tea_o, il_o, pflag_o;
    logic [4:0] req, burst, grant_o, m;
    logic [1:0] kind, array_size_i;
    logic [31:0] addr_i, dram_base_i;
    logic [3:0] boot_clocks_i;
    tmo_sel_t tmo_sel_i;
    int error_cnt, samples_checked, sz, nb, t;
    bit f32, wr, il, lan;
    lbus_arbiter u_lbus_arbiter (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .burst_i(burst), .write_i(write_i), .access_kind_lines_i(kind), .addr_i(addr_i),
        .parity_err_i(parity_err_i), .dram_base_i(dram_base_i), .array_size_i(array_size_i),
        .dev_16mbit_i(dev_16mbit_i), .dram_en_i(dram_en_i), .bus_32mhz_i(bus_32mhz_i),
        .parity_en_i(parity_en_i), .parity_trap_i(parity_trap_i),
        .boot_clocks_i(boot_clocks_i), .tmo_sel_i(tmo_sel_i), .grant_o(grant_o),
        .beat_ack_o(beat_ack_o), .transfer_error_ack_o(tea_o), .interleaved_o(il_o),
        .parity_flag_o(pflag_o));
    lbus_masters u_lbus_masters (.ref_clk_i(ref_clk_i), .grant_i(grant_o),
        .beat_ack_i(beat_ack_o), .tea_i(tea_o), .req_o(req), .burst_o(burst));
    function automatic int bt(bit f, bit w, bit i, bit first);
        if (w) return first ? (f ? 4 : 3) : 2;
        if (first) return f ? 5 : 4;
        return (f ? 2 : 1) + (i ? 0 : 1);
    endfunction : bt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic go(input logic [4:0] mk, input logic [4:0] b, input logic w,
                      input logic [31:0] a, input int lim);
        write_i = w;
        addr_i = a;
        kind = 2'($urandom_range(0, 2));
        u_lbus_masters.run(mk, b, lim);
    endtask : go
    task automatic reset_dut(input int n);
        @(negedge ref_clk_i);
        rst_n_i = 0;
        repeat (n) @(negedge ref_clk_i);
        rst_n_i = 1;
    endtask : reset_dut
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    initial begin
        ref_clk_i = 0;
        forever #(`CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #(20000 * `CLK_PERIOD_NS);
        error_cnt++;
        summarize();
    end
    initial begin
        {rst_n_i, write_i, parity_err_i, bus_32mhz_i, parity_en_i, parity_trap_i} = 6'h00;
        {kind, addr_i, dram_base_i, boot_clocks_i} = 70'h0;
        {dram_en_i, dev_16mbit_i, array_size_i} = 4'h9;
        tmo_sel_i = TMO_8US;
        t = $urandom(757);
        reset_dut(12);
        chk(grant_o, 5'h00);
        repeat (6) begin
            m = 5'($urandom_range(1, 31));
            while (m != 5'h00) begin
                go(m, 5'h00, 1, dram_base_i, 60);
                chk(u_lbus_masters.won, m & (~m + 5'h01));
                chk(u_lbus_masters.moved, 0);
                m &= ~u_lbus_masters.won;
            end
        end
        for (int i = 0; i < 24; i++) begin
            {wr, f32} = 2'(i);
            sz = (i / 4) % 3;
            {array_size_i, dev_16mbit_i} = {2'(sz), i >= 12};
            dram_base_i = {4'($urandom_range(0, 14)), 28'h0};
            bus_32mhz_i = f32;
            il = (sz == 0 && !dev_16mbit_i) || (sz == 2 && dev_16mbit_i);
            lan = $urandom_range(0, 1) && (wr || f32);
            nb = lan ? 1 : 4;
            go(lan ? 5'h01 : 5'h04, 5'h1F, wr, dram_base_i + ($urandom % (32'h400000 << sz)), 60);
            chk(il_o, il);
            chk(u_lbus_masters.evt.size(), nb);
            t = 0;
            for (int k = 0; k < nb; k++) begin
                t += bt(f32, wr, il, k == 0);
                chk(u_lbus_masters.evt[k], t);
            end
        end
        go(5'h08, 5'h00, 0, dram_base_i + (32'h400000 << sz), 200);
        chk(u_lbus_masters.evt[0], -`TMO_8US_CYC);
        for (int n = 2; n <= 11; n++) begin
            boot_clocks_i = 4'(n);
            nb = (n < 3) ? 3 : (n > 10 ? 10 : n);
            go(5'h10, 5'h00, 0, {10'h3FE, 22'($urandom)}, 100);
            chk(u_lbus_masters.evt[0], 4 * nb);
        end
        {bus_32mhz_i, array_size_i, dev_16mbit_i, parity_err_i} = 5'h05;
        for (int p = 0; p < 3; p++) begin
            // Off, check only, check and trap
            {parity_trap_i, parity_en_i} = {p == 2, p > 0};
            go(5'h10, 5'h00, 0, dram_base_i, 60);
            chk(pflag_o, p > 0);
            chk(u_lbus_masters.evt[0], (p == 2) ? -4 : 4);
        end
        tmo_sel_i = TMO_OFF;
        go(5'h08, 5'h00, 0, 32'hFF000000, 300);
        chk(u_lbus_masters.evt.size(), 0);
        reset_dut(3);
        chk(grant_o, 5'h00);
        chk(pflag_o, 0);
        summarize();
    end
endmodule : lbus_arbiter_tb_top

// File: verif/lbus_masters.sv
// Purpose: behavioural local bus masters facing the arbiter
// Assumes: requests change at the falling edge only
// Notes: logs ack (+n) and error ack (-n) clocks after grant
`timescale 1ns/1ns
module lbus_masters (
    input wire logic ref_clk_i,
    input wire logic [4:0] grant_i,
    input wire logic beat_ack_i,
    input wire logic tea_i,
    output logic [4:0] req_o,
    output logic [4:0] burst_o
);
    int evt[$];
    logic [4:0] won;
    bit moved;
    initial begin
        req_o = 5'h00;
        burst_o = 5'h00;
    end
    // Requests stay up until the owner's grant falls; a hang while granted drops all, a hang waiting for grant keeps all
    task automatic run(input logic [4:0] m, input logic [4:0] b, input int lim);
        int n;
        evt = {};
        moved = 0;
        @(negedge ref_clk_i);
        req_o = m;
        burst_o = b;
        n = 0;
        while (grant_i === 5'h00 && n < lim) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        won = grant_i;
        n = 0;
        while (grant_i !== 5'h00 && n < lim) begin
            @(posedge ref_clk_i);
            #1;
            n++;
            if (grant_i !== won && grant_i !== 5'h00) moved = 1;
            if (beat_ack_i === 1'b1) evt.push_back(n);
            if (tea_i === 1'b1) evt.push_back(-n);
        end
        @(negedge ref_clk_i);
        req_o = (n >= lim) ? 5'h00 : (req_o & ~won);
    endtask : run
endmodule : lbus_masters
